/* logic/twowire_slave_rx.sv */
// Two-wire bus target: address match, acknowledge and receive flags.
//
// Summary of operation
// - Ack matched address or data, then buffer it
// - Nack when buffer-full or overflow already set
// - Full buffer: keep it, set interrupt, overflow
// - Buffer read clears full; overflow cleared by software
// - Enabled: wait for START, then shift eight
// - Sample data on rising bus clock edge
// - Compare address bits 7:1 at eighth fall
// - Match: load buffer, set full at eighth fall
// - Ack in ninth clock, interrupt at ninth fall
// - Ten-bit first byte is 11110, A9, A8, 0
// - First ten-bit byte: flags, stretch until rewrite
// - Second ten-bit byte: flags, stretch until rewrite
// - Repeated START, read bit set: slave-transmit mode
`timescale 1ns/1ps
module twowire_slave_rx #(
  parameter int FIFO_W = twowire_pkg::BYTE_W,
  parameter int FIFO_D = twowire_pkg::FIFO_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic PORT_ENABLE,
  input wire logic TEN_BIT_MODE,
  input wire logic OWN_ADDR_WR,
  input wire logic [7:0] OWN_ADDR_WDATA,
  output logic [7:0] OWN_ADDR,
  input wire logic RX_BUF_RD,
  output logic [7:0] RX_BUF_DATA,
  output logic BUFFER_FULL,
  output logic RX_OVERFLOW,
  input wire logic OVERFLOW_CLR,
  output logic PORT_IRQ_FLAG,
  input wire logic IRQ_FLAG_CLR,
  input wire logic IRQ_ENABLE,
  output logic IRQ,
  output logic ADDR_UPDATE,
  output logic SLAVE_TX,
  output logic RW_BIT
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_IGNORE, ST_TX
  } state_e;
  typedef enum logic [1:0] {PH_ADDR, PH_ADDR_LOW, PH_DATA} phase_e;

  state_e state_q;
  phase_e phase_q;
  phase_e phase_d;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] own_q;
  logic [7:0] rxbuf_q;
  logic buf_loaded_q;
  logic bf_q;
  logic ov_q;
  logic irq_flag_q;
  logic irq_q;
  logic ua_q;
  logic tx_q;
  logic rw_q;
  logic matched10_q;
  logic ack_q;
  logic irq_pend_q;
  logic ua_pend_q;
  logic tx_pend_q;
  logic push_q;
  logic [7:0] push_data_q;
  logic sda_oe_q;
  logic scl_oe_q;

  logic scl_rise;
  logic scl_fall;
  logic sda_now;
  logic start_det;
  logic stop_det;
  logic eighth_fall;
  logic ninth_fall;
  logic hit;
  logic ten_first;
  logic want_ua;
  logic want_tx;
  logic busy;
  logic do_load;
  logic do_over;
  logic buf_read;

  byte_stream_if #(.W(FIFO_W)) fifo_in ();
  byte_stream_if #(.W(FIFO_W)) fifo_out ();

  pin_sampler u_pins (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .scl_pin(SCL_IN),
    .sda_pin(SDA_IN),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .sda_now(sda_now),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // The FIFO decouples the shift path from the buffer seen by software.
  byte_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );

  assign fifo_in.valid = push_q;
  assign fifo_in.data = push_data_q;
  assign fifo_out.ready = ~buf_loaded_q;

  assign eighth_fall = (state_q == ST_RECV) && scl_fall &&
                       (bit_cnt_q == twowire_pkg::BITS_PER_BYTE);
  assign ninth_fall = (state_q == ST_ACK) && scl_fall;
  assign buf_read = RX_BUF_RD;

  // A full FIFO counts as a full buffer, so back-pressure becomes a NACK.
  assign busy = bf_q | ov_q | ~fifo_in.ready;

  // Address decision taken on the eighth falling edge.
  always_comb begin
    hit = 1'b0;
    want_ua = 1'b0;
    want_tx = 1'b0;
    phase_d = phase_q;
    ten_first = shift_q[twowire_pkg::PREFIX_MSB:twowire_pkg::PREFIX_LSB]
                == twowire_pkg::TEN_BIT_PREFIX;
    case (phase_q)
      PH_ADDR: begin
        if (shift_q[twowire_pkg::ADDR_MSB:twowire_pkg::ADDR_LSB] ==
            own_q[twowire_pkg::ADDR_MSB:twowire_pkg::ADDR_LSB]) begin
          if (!TEN_BIT_MODE) begin
            hit = 1'b1;
            want_tx = shift_q[twowire_pkg::RW_POS];
            phase_d = PH_DATA;
          end else if (ten_first && !shift_q[twowire_pkg::RW_POS]) begin
            hit = 1'b1;
            want_ua = 1'b1;
            phase_d = PH_ADDR_LOW;
          end else if (ten_first && matched10_q) begin
            hit = 1'b1;
            want_tx = 1'b1;
            phase_d = PH_DATA;
          end
        end
      end
      PH_ADDR_LOW: begin
        if (shift_q == own_q) begin
          hit = 1'b1;
          want_ua = 1'b1;
          phase_d = PH_DATA;
        end
      end
      default: begin
        hit = 1'b1;
      end
    endcase
    do_load = eighth_fall && hit && !busy;
    do_over = eighth_fall && hit && bf_q;
  end

  // Bus sequencing: start, eight bits, ninth acknowledge clock.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
    end else if (!PORT_ENABLE) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (start_det) begin
      state_q <= ST_RECV;
      phase_q <= PH_ADDR;
      bit_cnt_q <= 4'h0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      phase_q <= PH_ADDR;
    end else begin
      case (state_q)
        ST_RECV: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_now};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (eighth_fall) begin
            state_q <= hit ? ST_ACK : ST_IGNORE;
            phase_q <= hit ? phase_d : phase_q;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            state_q <= tx_pend_q ? ST_TX : ST_RECV;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Per-byte decision held from the eighth to the ninth falling edge.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      irq_pend_q <= 1'b0;
      ua_pend_q <= 1'b0;
      tx_pend_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (eighth_fall) begin
      ack_q <= hit && !busy;
      irq_pend_q <= hit;
      ua_pend_q <= want_ua && !busy;
      tx_pend_q <= want_tx && !busy;
      if (phase_q == PH_ADDR) begin
        rw_q <= shift_q[twowire_pkg::RW_POS];
      end
    end
  end

  // Ten-bit sessions survive a repeated START but not a STOP.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      matched10_q <= 1'b0;
      tx_q <= 1'b0;
    end else if (!PORT_ENABLE || stop_det) begin
      matched10_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      if (eighth_fall && hit && phase_q == PH_ADDR_LOW) begin
        matched10_q <= 1'b1;
      end
      if (start_det) begin
        tx_q <= 1'b0;
      end else if (ninth_fall && tx_pend_q) begin
        tx_q <= 1'b1;
      end
    end
  end

  // Hand-off into the FIFO, one cycle after the eighth falling edge.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      push_q <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_q <= do_load;
      if (do_load) begin
        push_data_q <= shift_q;
      end
    end
  end

  // Receive buffer seen by software; refilled only after it was read.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxbuf_q <= twowire_pkg::RX_BUF_RESET;
      buf_loaded_q <= 1'b0;
    end else if (fifo_out.valid && !buf_loaded_q) begin
      rxbuf_q <= fifo_out.data;
      buf_loaded_q <= 1'b1;
    end else if (buf_read) begin
      buf_loaded_q <= 1'b0;
    end
  end

  // Status flags: a hardware set wins over a clear in the same cycle.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bf_q <= 1'b0;
      ov_q <= 1'b0;
      irq_flag_q <= 1'b0;
    end else begin
      if (do_load) begin
        bf_q <= 1'b1;
      end else if (buf_read) begin
        bf_q <= 1'b0;
      end
      if (do_over) begin
        ov_q <= 1'b1;
      end else if (OVERFLOW_CLR) begin
        ov_q <= 1'b0;
      end
      if (ninth_fall && irq_pend_q) begin
        irq_flag_q <= 1'b1;
      end else if (IRQ_FLAG_CLR) begin
        irq_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (irq_flag_q | (ninth_fall & irq_pend_q)) & IRQ_ENABLE;
    end
  end

  // Own address; rewriting it ends an address-update stretch.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      own_q <= twowire_pkg::OWN_ADDR_RESET;
    end else if (OWN_ADDR_WR) begin
      own_q <= OWN_ADDR_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ua_q <= 1'b0;
    end else if (!PORT_ENABLE) begin
      ua_q <= 1'b0;
    end else if (ninth_fall && ua_pend_q) begin
      ua_q <= 1'b1;
    end else if (OWN_ADDR_WR) begin
      ua_q <= 1'b0;
    end
  end

  // Open-drain drivers: data low for the acknowledge bit only, clock low
  // while the address update is pending. Stretching starts on the ninth
  // falling edge, when the master has already pulled the clock low.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      if (!PORT_ENABLE || start_det || stop_det || ninth_fall) begin
        sda_oe_q <= 1'b0;
      end else if (eighth_fall) begin
        sda_oe_q <= hit && !busy;
      end
      scl_oe_q <= PORT_ENABLE && ((ninth_fall && ua_pend_q) ||
                  (ua_q && !OWN_ADDR_WR));
    end
  end

  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;
  assign SDA_OE = sda_oe_q;
  assign SCL_OE = scl_oe_q;
  assign OWN_ADDR = own_q;
  assign RX_BUF_DATA = rxbuf_q;
  assign BUFFER_FULL = bf_q;
  assign RX_OVERFLOW = ov_q;
  assign PORT_IRQ_FLAG = irq_flag_q;
  assign IRQ = irq_q;
  assign ADDR_UPDATE = ua_q;
  assign SLAVE_TX = tx_q;
  assign RW_BIT = rw_q;
endmodule

/* logic/twowire_pkg.sv */
// Shared constants for the two-wire slave address receiver.
package twowire_pkg;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int RW_POS = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int PREFIX_MSB = 7;
  localparam int PREFIX_LSB = 3;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [7:0] OWN_ADDR_RESET = 8'h00;
  localparam logic [7:0] RX_BUF_RESET = 8'h00;
endpackage

/* logic/byte_stream_if.sv */
// Valid/ready byte stream between the receiver and its FIFO.
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* logic/pin_sampler.sv */
// Synchroniser and edge, start and stop detection for the bus pins.
`timescale 1ns/1ps
module pin_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl_rise,
  output logic scl_fall,
  output logic sda_now,
  output logic start_det,
  output logic stop_det
);
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= {scl_pin, sda_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Bit 1 is the clock line, bit 0 the data line.
  assign scl_rise = sync_q[1] & ~prev_q[1];
  assign scl_fall = ~sync_q[1] & prev_q[1];
  assign sda_now = sync_q[0];
  assign start_det = sync_q[1] & prev_q[1] & ~sync_q[0] & prev_q[0];
  assign stop_det = sync_q[1] & prev_q[1] & sync_q[0] & ~prev_q[0];
endmodule

/* logic/byte_fifo.sv */
// Parameterised FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem[rd_q];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* tb/twowire_slave_rx_monitor.sv */
// Port checks for the two-wire slave receiver.
`timescale 1ns/1ps
module twowire_slave_rx_monitor (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic PORT_ENABLE,
  input wire logic OWN_ADDR_WR,
  input wire logic RX_BUF_RD,
  input wire logic BUFFER_FULL,
  input wire logic RX_OVERFLOW,
  input wire logic OVERFLOW_CLR,
  input wire logic PORT_IRQ_FLAG,
  input wire logic ADDR_UPDATE
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence ack_begins;
    $rose(SDA_OE);
  endsequence
  sequence ack_held;
    SDA_OE [*8];
  endsequence
  a_off_released: assert property (
    (!PORT_ENABLE) [*3] |-> !SDA_OE && !SCL_OE)
    else $error("pin driven while disabled");
  a_ack_window: assert property (
    ack_begins |-> ack_held ##[1:300] !SDA_OE)
    else $error("acknowledge window wrong");
  a_flag_at_ninth: assert property (
    $fell(SDA_OE) |-> PORT_IRQ_FLAG)
    else $error("no interrupt flag after acknowledge");
  a_ack_needs_room: assert property (
    ack_begins |-> !$past(BUFFER_FULL) && !$past(RX_OVERFLOW))
    else $error("acknowledge with full buffer");
  a_load_acks: assert property (
    $rose(BUFFER_FULL) |-> ack_begins)
    else $error("buffer load without acknowledge");
  a_read_clears: assert property (
    RX_BUF_RD |=> !BUFFER_FULL)
    else $error("buffer read left full flag");
  a_ovf_sticky: assert property (
    RX_OVERFLOW && !OVERFLOW_CLR |=> RX_OVERFLOW)
    else $error("overflow dropped by itself");
  a_stretch_cause: assert property (
    $rose(SCL_OE) |-> ADDR_UPDATE && PORT_IRQ_FLAG)
    else $error("stretch without address update");
  a_stretch_end: assert property (
    OWN_ADDR_WR |=> !SCL_OE && !ADDR_UPDATE)
    else $error("address write kept the stretch");
endmodule

/* tb/twowire_master_model.sv */
// Behavioural bus master on the open-drain clock and data lines.
`timescale 1ns/1ps
module twowire_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // The slave may stretch, so the high phase starts when the line is high.
  // The wait is bounded so that a stuck line cannot hang the run.
  // The line only shows the release after this process has waited, so the
  // first poll comes one step later and the high phase stays at 80 ns.
  task automatic clk_high();
    int n;
    n = 0;
    scl_low = 1'b0;
    #10;
    while (scl_line !== 1'b1 && n < 3000) begin
      #10;
      n++;
    end
    #70;
  endtask
  task automatic start_c();
    sda_low = 1'b0;
    #40;
    clk_high();
    sda_low = 1'b1;
    #80;
    scl_low = 1'b1;
    #40;
  endtask
  task automatic stop_c();
    sda_low = 1'b1;
    #40;
    clk_high();
    sda_low = 1'b0;
    #80;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #40;
      clk_high();
      scl_low = 1'b1;
      #40;
    end
    sda_low = 1'b0;
    #40;
    clk_high();
    ack = ~sda_line;
    scl_low = 1'b1;
    #40;
  endtask
endmodule

/* tb/twowire_slave_rx_test.sv */
// Self-checking bench for the two-wire slave address receiver.
`timescale 1ns/1ps
module twowire_slave_rx_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic port_en, ten_bit, addr_wr, buf_rd, ovf_clr, flag_clr, irq_en;
  logic [7:0] addr_wdata, own_addr, rx_buf_data;
  logic scl_oe, sda_oe, buffer_full, rx_overflow, irq_flag, irq;
  logic addr_update, slave_tx, rw_bit, m_scl, m_sda, bf_prev;
  logic scl_out, sda_out;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int total_checks = 0;
  // Pull-ups on both lines: whoever pulls low wins.
  wire scl_line = !(m_scl || (scl_oe && !scl_out));
  wire sda_line = !(m_sda || (sda_oe && !sda_out));
  always #5 ref_clk = ~ref_clk;
  twowire_master_model m (.scl_line(scl_line), .sda_line(sda_line),
    .scl_low(m_scl), .sda_low(m_sda));
  twowire_slave_rx dut (.REF_CLK(ref_clk), .RST_N(rst_n),
    .SCL_IN(scl_line), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
    .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .PORT_ENABLE(port_en),
    .TEN_BIT_MODE(ten_bit), .OWN_ADDR_WR(addr_wr),
    .OWN_ADDR_WDATA(addr_wdata), .OWN_ADDR(own_addr), .RX_BUF_RD(buf_rd),
    .RX_BUF_DATA(rx_buf_data), .BUFFER_FULL(buffer_full),
    .RX_OVERFLOW(rx_overflow), .OVERFLOW_CLR(ovf_clr),
    .PORT_IRQ_FLAG(irq_flag), .IRQ_FLAG_CLR(flag_clr),
    .IRQ_ENABLE(irq_en), .IRQ(irq), .ADDR_UPDATE(addr_update),
    .SLAVE_TX(slave_tx), .RW_BIT(rw_bit));
  function automatic logic [5:0] fl();
    return {buffer_full, rx_overflow, irq_flag, irq, addr_update, scl_oe};
  endfunction
  task automatic chk_flag(input logic [5:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #1 s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_addr(input logic [7:0] v);
    @(posedge ref_clk);
    #1 addr_wdata = v;
    pulse(addr_wr);
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic ack;
    if (exp_ack) exp_q.push_back(b);
    m.send_byte(b, ack);
    chk_flag({5'h00, ack}, {5'h00, exp_ack}, "acknowledge");
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Each buffer load is matched against the oldest acknowledged byte.
  initial begin
    bf_prev = 1'b0;
    forever begin
      @(posedge ref_clk) #1;
      if (buffer_full === 1'b1 && bf_prev !== 1'b1) begin
        repeat (3) @(posedge ref_clk);
        #1;
        if (exp_q.size() == 0) chk_flag(6'h01, 6'h00, "stray load");
        else chk_byte(rx_buf_data, exp_q.pop_front(), "load");
      end
      bf_prev = buffer_full;
    end
  end
  initial begin
    #400000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    logic [7:0] a, d, h;
    {port_en, ten_bit, addr_wr, buf_rd, ovf_clr, flag_clr, irq_en} = '0;
    addr_wdata = 8'h00;
    void'($urandom(32'h1E1035D9));
    a = {7'($urandom_range(32'h7E, 32'h01)), 1'b1};
    d = 8'($urandom);
    h = {twowire_pkg::TEN_BIT_PREFIX, 2'($urandom), 1'b0};
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk_flag(fl(), 6'h00, "reset flags");
    chk_byte(own_addr, twowire_pkg::OWN_ADDR_RESET, "reset address");
    port_en = 1'b1;
    irq_en = 1'b1;
    set_addr(a);
    $display("reset test done");
    m.start_c();
    xfer({a[7:1], 1'b0}, 1'b1);
    chk_flag(fl(), 6'h2C, "address flags");
    pulse(buf_rd);
    pulse(flag_clr);
    xfer(d, 1'b1);
    xfer(~d, 1'b0);
    chk_flag(fl(), 6'h3C, "overflow flags");
    chk_byte(rx_buf_data, d, "buffer kept");
    m.stop_c();
    pulse(buf_rd);
    chk_flag(fl(), 6'h1C, "overflow sticky");
    pulse(flag_clr);
    m.start_c();
    xfer({a[7:1], 1'b0}, 1'b0);
    m.stop_c();
    chk_flag(fl(), 6'h1C, "overflow alone");
    pulse(ovf_clr);
    pulse(flag_clr);
    chk_flag(fl(), 6'h00, "flags cleared");
    $display("seven-bit receive test done");
    irq_en = 1'b0;
    m.start_c();
    xfer({a[7:1], 1'b1}, 1'b1);
    chk_flag(fl(), 6'h28, "masked flags");
    chk_flag({4'h0, rw_bit, slave_tx}, 6'h03, "read bit");
    m.stop_c();
    pulse(buf_rd);
    pulse(flag_clr);
    irq_en = 1'b1;
    m.start_c();
    xfer(a ^ 8'h02, 1'b0);
    chk_flag(fl(), 6'h00, "mismatch flags");
    m.stop_c();
    @(posedge ref_clk) #1 port_en = 1'b0;
    m.start_c();
    xfer(a, 1'b0);
    m.stop_c();
    chk_flag(fl(), 6'h00, "ignored flags");
    @(posedge ref_clk) #1 port_en = 1'b1;
    ten_bit = 1'b1;
    $display("mismatch and disable test done");
    set_addr(h);
    m.start_c();
    xfer(h, 1'b1);
    chk_flag(fl(), 6'h2F, "first byte stretch");
    set_addr(d);
    chk_byte(own_addr, d, "low address");
    pulse(buf_rd);
    pulse(flag_clr);
    chk_flag(fl(), 6'h00, "stretch released");
    xfer(d, 1'b1);
    chk_flag(fl(), 6'h2F, "second byte stretch");
    set_addr(h);
    pulse(buf_rd);
    pulse(flag_clr);
    m.start_c();
    xfer(h | 8'h01, 1'b1);
    chk_flag(fl(), 6'h2C, "read flags");
    chk_flag({5'h00, slave_tx}, 6'h01, "transmit mode");
    m.stop_c();
    chk_flag(6'(exp_q.size()), 6'h00, "missing load");
    $display("ten-bit test done");
    test_done();
  end
endmodule
bind twowire_slave_rx twowire_slave_rx_monitor mon (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .SCL_OE(SCL_OE), .SDA_OE(SDA_OE),
  .PORT_ENABLE(PORT_ENABLE), .OWN_ADDR_WR(OWN_ADDR_WR),
  .RX_BUF_RD(RX_BUF_RD), .BUFFER_FULL(BUFFER_FULL),
  .RX_OVERFLOW(RX_OVERFLOW), .OVERFLOW_CLR(OVERFLOW_CLR),
  .PORT_IRQ_FLAG(PORT_IRQ_FLAG), .ADDR_UPDATE(ADDR_UPDATE));
